//--- hdl/nvc_ctrl.sv
`timescale 1ns/100ps
module nvc_ctrl
   import nvc_pkg::*;
#(
   parameter int RESET_CYCLES = NVC_RESET_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire nvc_req_type REQ,
   input wire logic NVM_SEL_PIN,
   input wire logic NVM_DONE,
   input wire logic NVM_ERR,
   output logic [7:0] RDATA,
   output logic RVALID,
   output logic NVM_SAVE_START,
   output logic NVM_LOAD_START,
   output logic NVM_WR_ALLOW,
   output logic SOFT_RESET,
   output logic BUSY
);
   nvc_state_type state_r;
   logic wren_r;
   logic reload_r;
   logic save_r;
   logic err_r;
   logic [7:0] cnt_r;
   logic wr_ctl;
   logic wr_save;
   logic save_hit;
   logic reload_hit;
   logic reset_last;

   // true while the store is moving data in either direction
   function automatic logic in_transfer(input nvc_state_type st);
      in_transfer = (st == NVC_SAVE) || (st == NVC_LOAD);
   endfunction : in_transfer

   // decode of register writes
   assign wr_ctl = REQ.wr && (REQ.addr == NVC_ADDR_CONTROL);
   assign wr_save = REQ.wr && (REQ.addr == NVC_ADDR_SAVE);

   // accepted triggers; a save needs write enable, a reload needs the pin low
   assign save_hit = (state_r == NVC_IDLE) && wr_save && REQ.data[NVC_BIT_SAVE]
      && wren_r;
   assign reload_hit = (state_r == NVC_IDLE) && wr_ctl && REQ.data[NVC_BIT_RELOAD]
      && !NVM_SEL_PIN;
   assign reset_last = (state_r == NVC_RESET) && (cnt_r == 8'(RESET_CYCLES - 1));

   // write-enable bit; upper control bits ignored
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wren_r <= NVC_CONTROL_RESET[NVC_BIT_WREN];
      end else if (wr_ctl) begin
         wren_r <= REQ.data[NVC_BIT_WREN];
      end
   end

   // transfer sequencer: save, or reset then load
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         state_r <= NVC_IDLE;
         cnt_r <= 8'h00;
      end else begin
         unique case (state_r)
            NVC_IDLE: begin
               if (save_hit) begin
                  state_r <= NVC_SAVE;
               end else if (reload_hit) begin
                  state_r <= NVC_RESET;
                  cnt_r <= 8'h00;
               end
            end
            NVC_SAVE: begin
               if (NVM_DONE) begin
                  state_r <= NVC_IDLE;
               end
            end
            NVC_RESET: begin
               cnt_r <= cnt_r + 8'h01;
               if (reset_last) begin
                  state_r <= NVC_LOAD;
               end
            end
            NVC_LOAD: begin
               if (NVM_DONE) begin
                  state_r <= NVC_IDLE;
               end
            end
         endcase
      end
   end

   // self-clearing trigger bits track the sequencer
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         save_r <= NVC_SAVE_RESET[NVC_BIT_SAVE];
         reload_r <= 1'b0;
      end else begin
         if (save_hit) begin
            save_r <= 1'b1;
         end else if (state_r == NVC_SAVE && NVM_DONE) begin
            save_r <= 1'b0;
         end
         if (reload_hit) begin
            reload_r <= 1'b1;
         end else if (state_r == NVC_LOAD && NVM_DONE) begin
            reload_r <= 1'b0;
         end
      end
   end

   // error flag of the last transfer
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         err_r <= 1'b0;
      end else if (in_transfer(state_r) && NVM_DONE) begin
         err_r <= NVM_ERR;
      end
   end

   // start pulses to the store, one cycle each
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         NVM_SAVE_START <= 1'b0;
         NVM_LOAD_START <= 1'b0;
      end else begin
         NVM_SAVE_START <= save_hit;
         NVM_LOAD_START <= reset_last;
      end
   end

   // store write permission only while an enabled save runs
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         NVM_WR_ALLOW <= 1'b0;
      end else begin
         NVM_WR_ALLOW <= wren_r && (state_r == NVC_SAVE);
      end
   end

   // chip reset level and transfer status
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         SOFT_RESET <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         SOFT_RESET <= state_r == NVC_RESET;
         BUSY <= in_transfer(state_r);
      end
   end

   // read strobe echoed one cycle later
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RVALID <= 1'b0;
      end else begin
         RVALID <= REQ.rd;
      end
   end

   // read data; unused bits read zero
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= 8'h00;
         if (REQ.rd) begin
            unique case (REQ.addr)
               NVC_ADDR_BUSY: RDATA <= {7'h00, in_transfer(state_r)};
               NVC_ADDR_ERROR: RDATA <= {7'h00, err_r};
               NVC_ADDR_CONTROL: RDATA <= {6'h00, reload_r, wren_r};
               NVC_ADDR_SAVE: RDATA <= {7'h00, save_r};
               default: RDATA <= 8'h00;
            endcase
         end
      end
   end

   // checks on protection and save triggering
   a_save_blocked: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_save && !wren_r) |=> !NVM_SAVE_START) else $error("save while protected");
   a_allow_blocked: assert property (@(posedge MCLK) disable iff (!RST_N)
      !wren_r |=> !NVM_WR_ALLOW) else $error("store writes allowed while protected");
   a_save_start: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_IDLE && wr_save && REQ.data[0] && wren_r) |=> NVM_SAVE_START && save_r)
      else $error("save not started");
   a_save_refused: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r != NVC_IDLE) |=> !NVM_SAVE_START) else $error("save started while not idle");

   // checks on the self-clearing save bit and the busy flag
   a_save_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_SAVE && !NVM_DONE) |=> save_r && BUSY)
      else $error("save bit dropped early");
   a_save_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_SAVE && NVM_DONE) |=> !save_r && state_r == NVC_IDLE)
      else $error("save bit stuck");
   a_busy_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
      BUSY == $past(state_r == NVC_SAVE || state_r == NVC_LOAD)) else $error("busy wrong");
   a_idle_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_IDLE) |=> !SOFT_RESET && !BUSY) else $error("activity while idle");

   // checks on the soft reset and reload sequence
   a_reload_go: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_IDLE && wr_ctl && REQ.data[1] && !NVM_SEL_PIN && !(wr_save && wren_r))
      |=> reload_r ##1 SOFT_RESET) else $error("reload not started");
   a_reset_len: assert property (@(posedge MCLK) disable iff (!RST_N)
      $rose(SOFT_RESET) |-> SOFT_RESET [*4] ##1 !SOFT_RESET) else $error("reset length");
   a_load_after: assert property (@(posedge MCLK) disable iff (!RST_N)
      $rose(SOFT_RESET) |-> ##3 NVM_LOAD_START) else $error("load not started after reset");
   a_reload_pin: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_IDLE && wr_ctl && NVM_SEL_PIN && !wr_save)
      |=> state_r == NVC_IDLE && !reload_r && !SOFT_RESET)
      else $error("reload with pin high");
   a_reload_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_LOAD && !NVM_DONE) |=> reload_r) else $error("reload bit dropped early");
   a_reload_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_r == NVC_LOAD && NVM_DONE) |=> !reload_r) else $error("reload bit stuck");

   // read-back of the unused bits
   a_unused_bits: assert property (@(posedge MCLK) disable iff (!RST_N)
      RVALID |-> RDATA[7:2] == 6'h00) else $error("unused bits set");

   // main scenarios
   c_save: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_r == NVC_SAVE ##[1:20] state_r == NVC_IDLE);
   c_reload: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_r == NVC_LOAD ##[1:20] state_r == NVC_IDLE);
   c_blocked: cover property (@(posedge MCLK) disable iff (!RST_N) wr_save && !wren_r);
   c_pin_high: cover property (@(posedge MCLK) disable iff (!RST_N)
      wr_ctl && REQ.data[NVC_BIT_RELOAD] && NVM_SEL_PIN);
   c_store_err: cover property (@(posedge MCLK) disable iff (!RST_N)
      in_transfer(state_r) && NVM_DONE && NVM_ERR);
endmodule : nvc_ctrl

//--- hdl/nvc_pkg.sv
// Operation
// - with select pin low, writing one to bit 1 of control starts reset and reload
// - the reload bit clears itself when the reset and reload is done
// - write-enable bit zero, its reset value, blocks every write into the store
// - write-enable bit one permits software-started saves into the store
// - writing one to bit 0 of the save register starts a save
// - the save bit clears once the save into the store has fully completed
// - control bits 7 to 2 and save bits 7 to 1 have no function
// - busy status reads one while a transfer runs, zero once finished
package nvc_pkg;
   localparam logic [11:0] NVC_ADDR_BUSY = 12'hB00;
   localparam logic [11:0] NVC_ADDR_ERROR = 12'hB01;
   localparam logic [11:0] NVC_ADDR_CONTROL = 12'hB02;
   localparam logic [11:0] NVC_ADDR_SAVE = 12'hB03;
   localparam int NVC_BIT_WREN = 0;
   localparam int NVC_BIT_RELOAD = 1;
   localparam int NVC_BIT_SAVE = 0;
   localparam int NVC_BIT_BUSY = 0;
   localparam logic [7:0] NVC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] NVC_SAVE_RESET = 8'h00;
   localparam int NVC_CLK_MHZ = 50;
   localparam int NVC_IDLE_US = 10;
   localparam int NVC_IDLE_CYCLES = NVC_IDLE_US * NVC_CLK_MHZ;
   localparam int NVC_RESET_CYCLES = 4;

   // one register access from the serial control port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] data;
   } nvc_req_type;

   typedef enum logic [3:0] {
      NVC_IDLE = 4'h1,
      NVC_SAVE = 4'h2,
      NVC_LOAD = 4'h4,
      NVC_RESET = 4'h8
   } nvc_state_type;
endpackage : nvc_pkg

//--- tb/nvm_config_save_reload_ctrl_tb.sv
`timescale 1ns/100ps
module nvm_config_save_reload_ctrl_tb import nvc_pkg::*; ;
   logic mclk = 1'h0, rst_n = 1'h0, pin = 1'h1, done = 1'h0, err = 1'h0;
   nvc_req_type req = '0;
   logic [7:0] rdata, v;
   logic rvalid, save_go, load_go, wr_ok, soft_rst, busy;
   int failures = 0, checks = 0, n, m;

   // free-running control-port clock
   always #10 mclk = ~mclk;

   nvc_ctrl #(.RESET_CYCLES(NVC_RESET_CYCLES)) DUT (.MCLK(mclk), .RST_N(rst_n), .REQ(req),
      .NVM_SEL_PIN(pin), .NVM_DONE(done), .NVM_ERR(err), .RDATA(rdata), .RVALID(rvalid),
      .NVM_SAVE_START(save_go), .NVM_LOAD_START(load_go), .NVM_WR_ALLOW(wr_ok),
      .SOFT_RESET(soft_rst), .BUSY(busy));

   // compares one byte and counts it
   task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   // one register write, strobe held for a single edge
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      req <= '0;
   endtask : wr

   // one register read, data taken while the valid pulse stands
   task rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      req <= '0;
      #1;
      cmp("read valid", 8'h01, {7'h00, rvalid});
      d = rdata;
   endtask : rd

   // store reports the end of a transfer, then the host keeps idle
   task fin(input logic e);
      @(posedge mclk);
      done <= 1'b1;
      err <= e;
      @(posedge mclk);
      done <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask : fin

   // count soft reset cycles and load strobes over a fixed span
   task watch(input int cyc);
      n = 0;
      m = 0;
      repeat (cyc) begin
         @(posedge mclk);
         #1;
         n += soft_rst;
         m += load_go;
      end
   endtask : watch

   // reset values, an unmapped address and a save refused while protected
   task t_locked;
      rd(NVC_ADDR_CONTROL, v);
      cmp("control", 8'h00, v);
      rd(NVC_ADDR_SAVE, v);
      cmp("save", 8'h00, v);
      rd(12'h000, v);
      cmp("unmapped", 8'h00, v);
      wr(NVC_ADDR_SAVE, 8'h01);
      #1;
      cmp("save start", 8'h00, {7'h00, save_go});
      @(posedge mclk);
      #1;
      cmp("write allow", 8'h00, {7'h00, wr_ok});
      cmp("busy out", 8'h00, {7'h00, busy});
      rd(NVC_ADDR_SAVE, v);
      cmp("save", 8'h00, v);
   endtask : t_locked

   // unprotected save with busy polling, then the host idle gap
   task t_save;
      wr(NVC_ADDR_CONTROL, 8'hFD);
      rd(NVC_ADDR_CONTROL, v);
      cmp("control", 8'h01, v);
      wr(NVC_ADDR_SAVE, 8'hFF);
      #1;
      cmp("save start", 8'h01, {7'h00, save_go});
      @(posedge mclk);
      #1;
      cmp("write allow", 8'h01, {7'h00, wr_ok});
      cmp("busy out", 8'h01, {7'h00, busy});
      rd(NVC_ADDR_SAVE, v);
      cmp("save", 8'h01, v);
      rd(NVC_ADDR_BUSY, v);
      cmp("busy", 8'h01, v);
      fin(1'b1);
      cmp("busy out", 8'h00, {7'h00, busy});
      rd(NVC_ADDR_SAVE, v);
      cmp("save", 8'h00, v);
      rd(NVC_ADDR_BUSY, v);
      cmp("busy", 8'h00, v);
      rd(NVC_ADDR_ERROR, v);
      cmp("error", 8'h01, v);
      repeat (NVC_IDLE_CYCLES) @(posedge mclk);
   endtask : t_save

   // reload ignored with the pin high, carried out with it low
   task t_reload;
      wr(NVC_ADDR_CONTROL, 8'h03);
      watch(8);
      cmp("soft reset cycles", 8'h00, n[7:0]);
      rd(NVC_ADDR_CONTROL, v);
      cmp("reload bit", 8'h00, v & 8'h02);
      @(posedge mclk);
      pin <= 1'b0;
      wr(NVC_ADDR_CONTROL, 8'h02);
      watch(10);
      cmp("soft reset cycles", 8'(NVC_RESET_CYCLES), n[7:0]);
      cmp("load starts", 8'h01, m[7:0]);
      cmp("busy out", 8'h01, {7'h00, busy});
      rd(NVC_ADDR_CONTROL, v);
      cmp("reload bit", 8'h02, v & 8'h02);
      fin(1'b0);
      rd(NVC_ADDR_CONTROL, v);
      cmp("reload bit", 8'h00, v & 8'h02);
   endtask : t_reload

   // prints the verdict and ends the run
   task summarize;
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_locked;
      t_save;
      t_reload;
      summarize;
   end

   // watchdog well beyond the expected run time
   initial begin
      #200000;
      failures++;
      summarize;
   end
endmodule : nvm_config_save_reload_ctrl_tb
